// file: rtl/cn_defines.vh
/*
  Constants of the CANopen slave protocol block: SDO codes, abort codes,
  COB identifier bases, NMT commands and states, timing and register map.
  Assumes inclusion by bare name from the design files under rtl/.
*/
`ifndef CN_DEFINES_VH
`define CN_DEFINES_VH

`define CN_RQ_WR4       8'h23
`define CN_RQ_WR2       8'h2B
`define CN_RQ_WR1       8'h2F
`define CN_RQ_RD        8'h40
`define CN_RQ_CANCEL    8'h80
`define CN_RS_RD4       8'h43
`define CN_RS_RD2       8'h4B
`define CN_RS_RD1       8'h4F
`define CN_RS_WR        8'h60
`define CN_RS_ABORT     8'h80

`define CN_AB_TOGGLE    32'h05030000
`define CN_AB_CMD       32'h05040001
`define CN_AB_ACCESS    32'h06010000
`define CN_AB_RDONLY    32'h06010002
`define CN_AB_NOINDEX   32'h06020000
`define CN_AB_NOMAP     32'h06040041
`define CN_AB_MAPLEN    32'h06040042
`define CN_AB_NOSUB     32'h06090011
`define CN_AB_LIMIT     32'h06090030
`define CN_AB_HIGH      32'h06090031
`define CN_AB_GENERAL   32'h08000000

`define CN_COB_NMT      11'h000
`define CN_COB_SYNC     11'h080
`define CN_COB_TPDO     11'h180
`define CN_COB_RPDO     11'h200
`define CN_COB_TSDO     11'h580
`define CN_COB_RSDO     11'h600
`define CN_COB_BOOT     11'h700
`define CN_SDO_DLC      4'h8

`define CN_CS_START     8'h01
`define CN_CS_STOP      8'h02
`define CN_CS_PREOP     8'h80
`define CN_CS_RST_NODE  8'h81
`define CN_CS_RST_COMM  8'h82

`define CN_ST_INIT      7'h00
`define CN_ST_STOP      7'h04
`define CN_ST_OPER      7'h05
`define CN_ST_PREOP     7'h7F

`define CN_TT_ACYC      8'h00
`define CN_TT_CYC_MAX   8'hF0
`define CN_TT_ASYNC     8'hFE
`define CN_TT_DEFAULT   8'hFF
`define CN_EVT_MAX      16'hEA60

`define CN_MAP_STATUS   32'h60410010
`define CN_MAP_CURRENT  32'h20020510
`define CN_MAP_THERMAL  32'h20421F10
`define CN_MAP_FAULT    32'h20380710
`define CN_MAP_MAX      8'h04

`define CN_TICK_NS      100000
`define CN_CLK_KHZ      25000
`define CN_MS_TICKS     10

`define CN_REG_NODE     4'h0
`define CN_REG_STAT     4'h4
`define CN_NODE_RST     7'h01
`endif

// file: rtl/cn_tick.v
/*
  Time base: a 100 us enable pulse and a 1 ms enable pulse.
  Assumes one free-running system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cn_tick #(
  parameter DIV = 2500,
  parameter MS  = 10
) (
  input  wire       sys_clk,
  input  wire       rst_n,
  output reg        tick,
  output reg        ms_tick
);
  reg [11:0] cnt;
  reg [3:0]  mcnt;

  always @(posedge sys_clk) begin
    tick    <= 1'b0;
    ms_tick <= 1'b0;
    if (!rst_n) begin
      cnt  <= 12'h000;
      mcnt <= 4'h0;
    end else if (cnt == DIV[11:0] - 12'h001) begin
      cnt  <= 12'h000;
      tick <= 1'b1;
      if (mcnt == MS[3:0] - 4'h1) begin
        mcnt    <= 4'h0;
        ms_tick <= 1'b1;
      end else begin
        mcnt <= mcnt + 4'h1;
      end
    end else begin
      cnt <= cnt + 12'h001;
    end
  end
endmodule
`default_nettype wire

// file: rtl/cn_tpdo_trig.v
/*
  Transmit trigger of one PDO: asynchronous, cyclic and acyclic
  synchronous modes with inhibit time and event timer.
  Assumes change, sync and sent are one-cycle pulses on sys_clk.
*/
`include "cn_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module cn_tpdo_trig (
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire       en,
  input  wire [7:0] tx_type,
  input  wire [15:0] inhibit,
  input  wire [15:0] event_ms,
  input  wire       tick,
  input  wire       ms_tick,
  input  wire       changed,
  input  wire       sync,
  input  wire       sent,
  output wire       req
);
  reg        pend;
  reg        armed;
  reg [7:0]  sync_cnt;
  reg [15:0] inh_cnt;
  reg [15:0] ev_cnt;

  wire is_async = tx_type >= `CN_TT_ASYNC;
  wire is_acyc  = tx_type == `CN_TT_ACYC;
  wire is_cyc   = !is_acyc && tx_type <= `CN_TT_CYC_MAX;
  wire ev_fire  = is_async && event_ms != 16'h0000 && ms_tick &&
                  ev_cnt + 16'h0001 >= event_ms;
  wire cyc_hit  = is_cyc && sync &&
                  sync_cnt + 8'h01 >= tx_type;
  wire acyc_hit = is_acyc && sync && armed;
  wire set      = (is_async && changed) || ev_fire || cyc_hit || acyc_hit;

  // Inhibit time holds a pending request back, it never drops it
  assign req = pend && inh_cnt == 16'h0000;

  always @(posedge sys_clk) begin
    if (!rst_n || !en) begin
      pend     <= 1'b0;
      armed    <= 1'b0;
      sync_cnt <= 8'h00;
      inh_cnt  <= 16'h0000;
      ev_cnt   <= 16'h0000;
    end else begin
      pend <= (pend && !sent) || set;
      // A change in the SYNC cycle waits for the next SYNC
      armed <= is_acyc && ((armed && !sync) || changed);
      if (sent)
        inh_cnt <= inhibit;
      else if (tick && inh_cnt != 16'h0000)
        inh_cnt <= inh_cnt - 16'h0001;
      if (sent || !is_async)
        ev_cnt <= 16'h0000;
      else if (ms_tick)
        ev_cnt <= ev_cnt + 16'h0001;
      if (!is_cyc || cyc_hit)
        sync_cnt <= 8'h00;
      else if (sync)
        sync_cnt <= sync_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// file: rtl/cn_slave.v
/*
  CANopen slave protocol logic: NMT state machine, expedited SDO server,
  three PDO pairs and a small register port.
  Assumes a frame controller on sys_clk that presents received frames
  with valid/ready and accepts frames to send with valid/ready.
  Frame data byte 0 sits in bits 7:0.
*/
`include "cn_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module cn_slave #(
  parameter TICK_CYC = `CN_TICK_NS / 1000 * `CN_CLK_KHZ / 1000
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        rx_valid,
  output wire        rx_ready,
  input  wire [10:0] rx_id,
  input  wire [3:0]  rx_dlc,
  input  wire [63:0] rx_data,
  output reg         tx_valid,
  input  wire        tx_ready,
  output reg  [10:0] tx_id,
  output reg  [3:0]  tx_dlc,
  output reg  [63:0] tx_data,
  input  wire [15:0] status_word,
  input  wire [15:0] motor_current,
  input  wire [15:0] motor_thermal_state,
  input  wire [15:0] fault_code,
  input  wire [63:0] scanner_input_words,
  output reg  [15:0] command_word,
  output reg         command_strobe,
  output reg  [63:0] rpdo2_words,
  output reg  [63:0] scanner_output_words,
  output reg  [6:0]  nmt_state
);
  localparam SZ1 = 2'd1;
  localparam SZ2 = 2'd2;
  localparam SZ4 = 2'd3;

  reg  [6:0]  node_id;
  reg         boot_pend;
  reg         sdo_pend;
  reg  [63:0] sdo_frame;
  reg  [2:0]  tx_inval;
  reg  [2:0]  rx_inval;
  reg  [7:0]  tx_type [0:2];
  reg  [15:0] inhibit [0:2];
  reg  [15:0] evtmr   [0:2];
  reg  [7:0]  map_cnt;
  reg  [31:0] map_ent [0:3];
  reg  [63:0] pdo_prev [0:2];
  reg  [63:0] pdo_data [0:2];
  reg  [3:0]  pdo_dlc  [0:2];
  reg  [15:0] map_src;
  wire        tick;
  wire        ms_tick;
  wire [2:0]  pdo_req;
  reg  [2:0]  pdo_sent;
  integer     k;
  integer     j;
  integer     m;
  // A request is still up in the cycle after its frame was loaded
  wire [2:0]  pdo_want = pdo_req & ~pdo_sent;
  wire [1:0]  pdo_sel  = pdo_want[0] ? 2'h0 : pdo_want[1] ? 2'h1 : 2'h2;

  wire take     = rx_valid && rx_ready;
  wire oper     = nmt_state == `CN_ST_OPER;
  wire preop    = nmt_state == `CN_ST_PREOP;
  wire is_nmt   = rx_id == `CN_COB_NMT && rx_dlc >= 4'h2;
  wire is_sync  = rx_id == `CN_COB_SYNC && rx_dlc == 4'h0;
  wire is_sdo   = rx_id == `CN_COB_RSDO + {4'h0, node_id};
  wire nmt_hit  = take && is_nmt &&
                  (rx_data[15:8] == {1'b0, node_id} ||
                   rx_data[15:8] == 8'h00);
  wire [7:0] nmt_cs = rx_data[7:0];
  wire rst_node = nmt_hit && nmt_cs == `CN_CS_RST_NODE;
  wire rst_comm = !rst_n || rst_node ||
                  (nmt_hit && nmt_cs == `CN_CS_RST_COMM);
  wire sync_p   = take && is_sync && (preop || oper);

  // Only SDO frames wait; a held response must leave before the next
  assign rx_ready = !(is_sdo && sdo_pend);

  cn_tick #(
    .DIV (TICK_CYC),
    .MS  (`CN_MS_TICKS)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (tick),
    .ms_tick (ms_tick)
  );

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_trig
      cn_tpdo_trig u_trig (
        .sys_clk  (sys_clk),
        .rst_n    (!rst_comm),
        .en       (oper && !tx_inval[g] && pdo_dlc[g] != 4'h0),
        .tx_type  (tx_type[g]),
        .inhibit  (inhibit[g]),
        .event_ms (evtmr[g]),
        .tick     (tick),
        .ms_tick  (ms_tick),
        .changed  (pdo_data[g] != pdo_prev[g]),
        .sync     (sync_p),
        .sent     (pdo_sent[g]),
        .req      (pdo_req[g])
      );
    end
  endgenerate

  // Transmit PDO contents
  always @* begin
    pdo_data[0] = {fault_code, motor_thermal_state,
                   motor_current, status_word};
    pdo_dlc[0]  = 4'h8;
    pdo_data[1] = 64'h0;
    pdo_dlc[1]  = {map_cnt[2:0], 1'b0};
    for (k = 0; k < 4; k = k + 1) begin
      case (map_ent[k])
        `CN_MAP_STATUS:  map_src = status_word;
        `CN_MAP_CURRENT: map_src = motor_current;
        `CN_MAP_THERMAL: map_src = motor_thermal_state;
        `CN_MAP_FAULT:   map_src = fault_code;
        default:         map_src = 16'h0000;
      endcase
      if (k < map_cnt)
        pdo_data[1][16*k +: 16] = map_src;
    end
    pdo_data[2] = scanner_input_words;
    pdo_dlc[2]  = 4'h8;
  end

  // SDO request fields
  wire [7:0]  rq_code = rx_data[7:0];
  wire [15:0] rq_idx  = rx_data[23:8];
  wire [7:0]  rq_sub  = rx_data[31:24];
  wire [31:0] rq_val  = rx_data[63:32];
  wire [1:0]  pn      = rq_idx[1:0];

  reg        ob_idx;
  reg        ob_sub;
  reg        ob_ro;
  reg [1:0]  ob_sz;
  reg [31:0] ob_val;
  reg [1:0]  wr_sz;
  reg        wr_ok;
  reg [7:0]  rs_code;
  reg [31:0] rs_data;

  // Object dictionary lookup
  always @* begin
    ob_idx = 1'b0;
    ob_sub = 1'b0;
    ob_ro  = 1'b0;
    ob_sz  = SZ1;
    ob_val = 32'h0;
    case (rq_idx)
      16'h1400, 16'h1401, 16'h1402: begin
        ob_idx = 1'b1;
        ob_sub = rq_sub == 8'h01;
        ob_sz  = SZ4;
        ob_val = {rx_inval[pn], 20'h0,
                  `CN_COB_RPDO + {1'b0, pn, 8'h00} + {4'h0, node_id}};
      end
      16'h1800, 16'h1801, 16'h1802: begin
        ob_idx = 1'b1;
        case (rq_sub)
          8'h01: begin
            ob_sub = 1'b1;
            ob_sz  = SZ4;
            ob_val = {tx_inval[pn], 20'h0,
                      `CN_COB_TPDO + {1'b0, pn, 8'h00} + {4'h0, node_id}};
          end
          8'h02: begin
            ob_sub = 1'b1;
            ob_val = {24'h0, tx_type[pn]};
          end
          8'h03: begin
            ob_sub = 1'b1;
            ob_sz  = SZ2;
            ob_val = {16'h0, inhibit[pn]};
          end
          8'h05: begin
            ob_sub = 1'b1;
            ob_sz  = SZ2;
            ob_val = {16'h0, evtmr[pn]};
          end
          default: ob_sub = 1'b0;
        endcase
      end
      16'h1A00, 16'h1A02: begin
        ob_idx = 1'b1;
        ob_sub = rq_sub == 8'h00;
        ob_ro  = 1'b1;
        ob_val = {24'h0, `CN_MAP_MAX};
      end
      16'h1A01: begin
        ob_idx = 1'b1;
        ob_sub = rq_sub <= `CN_MAP_MAX;
        ob_sz  = rq_sub == 8'h00 ? SZ1 : SZ4;
        ob_val = rq_sub == 8'h00 ? {24'h0, map_cnt} :
                 map_ent[rq_sub[1:0] - 2'd1];
      end
      16'h6040: begin
        ob_idx = 1'b1;
        ob_sub = rq_sub == 8'h00;
        ob_sz  = SZ2;
        ob_val = {16'h0, command_word};
      end
      16'h6041, 16'h2002, 16'h2042, 16'h2038: begin
        ob_idx = 1'b1;
        ob_ro  = 1'b1;
        ob_sz  = SZ2;
        case (rq_idx)
          16'h6041: begin
            ob_sub = rq_sub == 8'h00;
            ob_val = {16'h0, status_word};
          end
          16'h2002: begin
            ob_sub = rq_sub == 8'h05;
            ob_val = {16'h0, motor_current};
          end
          16'h2042: begin
            ob_sub = rq_sub == 8'h1F;
            ob_val = {16'h0, motor_thermal_state};
          end
          default: begin
            ob_sub = rq_sub == 8'h07;
            ob_val = {16'h0, fault_code};
          end
        endcase
      end
      default: ob_idx = 1'b0;
    endcase
  end

  // Answer selection; the order fixes which abort wins
  always @* begin
    wr_ok   = 1'b0;
    rs_code = `CN_RS_ABORT;
    rs_data = `CN_AB_GENERAL;
    case (rq_code)
      `CN_RQ_WR4: wr_sz = SZ4;
      `CN_RQ_WR2: wr_sz = SZ2;
      default:    wr_sz = SZ1;
    endcase
    if (rq_code[7:5] == 3'b000 || rq_code[7:5] == 3'b011)
      rs_data = `CN_AB_TOGGLE;
    else if (rq_code != `CN_RQ_WR4 && rq_code != `CN_RQ_WR2 &&
             rq_code != `CN_RQ_WR1 && rq_code != `CN_RQ_RD)
      rs_data = `CN_AB_CMD;
    else if (!ob_idx)
      rs_data = `CN_AB_NOINDEX;
    else if (!ob_sub)
      rs_data = `CN_AB_NOSUB;
    else if (rq_code == `CN_RQ_RD) begin
      rs_data = ob_val;
      rs_code = ob_sz == SZ4 ? `CN_RS_RD4 :
                ob_sz == SZ2 ? `CN_RS_RD2 : `CN_RS_RD1;
    end else if (ob_ro)
      rs_data = `CN_AB_RDONLY;
    else if (wr_sz != ob_sz ||
             (wr_sz == SZ2 && rq_val[31:16] != 16'h0000) ||
             (wr_sz == SZ1 && rq_val[31:8] != 24'h000000))
      rs_data = `CN_AB_GENERAL;
    else if (rq_idx == 16'h1A01 && !tx_inval[1])
      rs_data = `CN_AB_ACCESS;
    else if (rq_idx[15:8] == 8'h18 && rq_sub == 8'h02 &&
             rq_val[7:0] > `CN_TT_CYC_MAX && rq_val[7:0] < `CN_TT_ASYNC)
      rs_data = `CN_AB_LIMIT;
    else if (rq_idx[15:8] == 8'h18 && rq_sub == 8'h05 &&
             rq_val[15:0] > `CN_EVT_MAX)
      rs_data = `CN_AB_HIGH;
    else if (rq_idx == 16'h1A01 && rq_sub == 8'h00 &&
             rq_val[7:0] > `CN_MAP_MAX)
      rs_data = `CN_AB_MAPLEN;
    else if (rq_idx == 16'h1A01 && rq_sub != 8'h00 &&
             rq_val != `CN_MAP_STATUS && rq_val != `CN_MAP_CURRENT &&
             rq_val != `CN_MAP_THERMAL && rq_val != `CN_MAP_FAULT)
      rs_data = `CN_AB_NOMAP;
    else begin
      wr_ok   = 1'b1;
      rs_code = `CN_RS_WR;
      rs_data = 32'h0;
    end
  end

  wire sdo_take = take && is_sdo && (preop || oper) &&
                  rx_dlc == `CN_SDO_DLC;
  wire sdo_cancel = rq_code == `CN_RQ_CANCEL;

  // NMT state machine
  always @(posedge sys_clk) begin
    if (rst_comm) begin
      nmt_state <= `CN_ST_INIT;
      boot_pend <= 1'b0;
    end else begin
      case (nmt_state)
        `CN_ST_INIT: begin
          nmt_state <= `CN_ST_PREOP;
          boot_pend <= 1'b1;
        end
        `CN_ST_PREOP, `CN_ST_OPER, `CN_ST_STOP: begin
          if (nmt_hit && nmt_cs == `CN_CS_START)
            nmt_state <= `CN_ST_OPER;
          else if (nmt_hit && nmt_cs == `CN_CS_STOP)
            nmt_state <= `CN_ST_STOP;
          else if (nmt_hit && nmt_cs == `CN_CS_PREOP)
            nmt_state <= `CN_ST_PREOP;
        end
        default: nmt_state <= `CN_ST_INIT;
      endcase
      if (boot_pend && (!tx_valid || tx_ready) && pdo_want == 3'b000 &&
          !sdo_pend)
        boot_pend <= 1'b0;
    end
  end

  // SDO server and communication objects
  always @(posedge sys_clk) begin
    if (rst_comm) begin
      sdo_pend <= 1'b0;
      sdo_frame <= 64'h0;
      tx_inval <= 3'b110;
      rx_inval <= 3'b110;
      map_cnt  <= 8'h00;
      for (j = 0; j < 4; j = j + 1)
        map_ent[j] <= 32'h0;
      for (j = 0; j < 3; j = j + 1) begin
        tx_type[j] <= `CN_TT_DEFAULT;
        inhibit[j] <= 16'h0000;
        evtmr[j]   <= 16'h0000;
      end
    end else begin
      if (sdo_pend && (!tx_valid || tx_ready) && pdo_want == 3'b000)
        sdo_pend <= 1'b0;
      if (sdo_take && !sdo_cancel) begin
        sdo_pend  <= 1'b1;
        sdo_frame <= {rs_data, rq_sub, rq_idx, rs_code};
      end
      if (sdo_take && wr_ok) begin
        case (rq_idx[15:8])
          8'h14: rx_inval[pn] <= rq_val[31];
          8'h18: begin
            case (rq_sub)
              8'h01:   tx_inval[pn] <= rq_val[31];
              8'h02:   tx_type[pn]  <= rq_val[7:0];
              8'h03:   inhibit[pn]  <= rq_val[15:0];
              default: evtmr[pn]    <= rq_val[15:0];
            endcase
          end
          8'h1A: begin
            if (rq_sub == 8'h00)
              map_cnt <= rq_val[7:0];
            else
              map_ent[rq_sub[1:0] - 2'd1] <= rq_val;
          end
          default: map_cnt <= map_cnt;
        endcase
      end
    end
  end

  // Receive PDOs and application outputs
  wire [10:0] rp_off = rx_id - `CN_COB_RPDO - {4'h0, node_id};
  wire        rp_hit = take && oper && rp_off[7:0] == 8'h00 &&
                       rp_off[10:8] < 3'd3;
  wire [1:0]  rp_n   = rp_off[9:8];

  always @(posedge sys_clk) begin
    command_strobe <= 1'b0;
    if (!rst_n || rst_node) begin
      command_word         <= 16'h0000;
      rpdo2_words          <= 64'h0;
      scanner_output_words <= 64'h0;
    end else if (sdo_take && wr_ok && rq_idx == 16'h6040) begin
      command_word   <= rq_val[15:0];
      command_strobe <= 1'b1;
    end else if (rp_hit && !rx_inval[rp_n]) begin
      case (rp_n)
        2'd0: begin
          command_word   <= rx_data[15:0];
          command_strobe <= 1'b1;
        end
        2'd1:    rpdo2_words <= rx_data;
        default: scanner_output_words <= rx_data;
      endcase
    end
  end

  // Transmit arbiter: lower identifiers first, as on the bus
  always @(posedge sys_clk) begin
    pdo_sent <= 3'b000;
    if (rst_comm) begin
      tx_valid <= 1'b0;
      tx_id    <= 11'h000;
      tx_dlc   <= 4'h0;
      tx_data  <= 64'h0;
      for (m = 0; m < 3; m = m + 1)
        pdo_prev[m] <= 64'h0;
    end else if (!tx_valid || tx_ready) begin
      tx_valid <= 1'b0;
      if (pdo_want != 3'b000) begin
        tx_valid    <= 1'b1;
        tx_id       <= `CN_COB_TPDO + {1'b0, pdo_sel, 8'h00} +
                       {4'h0, node_id};
        tx_dlc      <= pdo_dlc[pdo_sel];
        tx_data     <= pdo_data[pdo_sel];
        pdo_prev[pdo_sel] <= pdo_data[pdo_sel];
        pdo_sent[pdo_sel] <= 1'b1;
      end else if (sdo_pend) begin
        tx_valid <= 1'b1;
        tx_id    <= `CN_COB_TSDO + {4'h0, node_id};
        tx_dlc   <= `CN_SDO_DLC;
        tx_data  <= sdo_frame;
      end else if (boot_pend) begin
        tx_valid <= 1'b1;
        tx_id    <= `CN_COB_BOOT + {4'h0, node_id};
        tx_dlc   <= 4'h1;
        tx_data  <= 64'h0;
      end
    end
  end

  // Register port; node identity takes effect on the write, without a reset communication
  always @(posedge sys_clk) begin
    reg_rdata <= 32'h0;
    if (!rst_n) begin
      node_id <= `CN_NODE_RST;
    end else begin
      if (reg_wr && reg_addr == `CN_REG_NODE)
        node_id <= reg_wdata[6:0];
      if (reg_rd && reg_addr == `CN_REG_NODE)
        reg_rdata <= {25'h0, node_id};
      else if (reg_rd && reg_addr == `CN_REG_STAT)
        reg_rdata <= {16'h0, 5'h0, tx_inval, sdo_pend, nmt_state};
    end
  end
endmodule
`default_nettype wire

// file: rtl/cn_slave_end.v
/*
  Empty end marker for the design file set.
  Assumes nothing.
*/

// file: bench/cn_slave_sva.sv
/*
  Port checker of the CANopen slave block.
  Assumes binding to cn_slave from the testbench top, one clock domain.
*/
`include "cn_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module cn_slave_sva (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [10:0] tx_id,
  input wire logic [3:0]  tx_dlc,
  input wire logic [63:0] tx_data,
  input wire logic [6:0]  nmt_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_sdo_out;
    tx_valid && tx_id[10:7] == 4'hB;
  endsequence
  sequence s_code(logic [7:0] c);
    s_sdo_out ##0 tx_data[7:0] == c;
  endsequence
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid
    && $stable(tx_id) && $stable(tx_data) && $stable(tx_dlc)) else $error("tx dropped");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("rdata not idle");
  a_boot_preop: assert property ($rose(rst_n) |=> nmt_state == `CN_ST_PREOP)
    else $error("no preop after reset");
  a_sdo_len: assert property (s_sdo_out |-> tx_dlc == `CN_SDO_DLC)
    else $error("sdo length");
  a_sdo_code: assert property (s_sdo_out |-> tx_data[7:0] inside {`CN_RS_RD4,
    `CN_RS_RD2, `CN_RS_RD1, `CN_RS_WR, `CN_RS_ABORT}) else $error("sdo code");
  a_wr_zero: assert property (s_code(`CN_RS_WR) |-> tx_data[63:32] == 32'h0)
    else $error("write ack data");
  a_rd2_pad: assert property (s_code(`CN_RS_RD2) |-> tx_data[63:48] == 16'h0)
    else $error("read pad");
  a_pdo_oper: assert property (tx_valid && tx_id[10:7] inside {4'h3, 4'h5, 4'h7}
    |-> nmt_state == `CN_ST_OPER) else $error("pdo outside oper");
endmodule
`default_nettype wire

// file: bench/cn_ctl_model.sv
/*
  Frame controller model on the slave's transmit side.
  Assumes the slave holds each frame until tx_ready.
*/
`timescale 1ns/1ns
`default_nettype none
module cn_ctl_model (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic slow,
  output var  logic tx_ready
);
  logic [2:0] cnt;
  always_ff @(posedge sys_clk) begin
    cnt <= rst_n ? cnt + 3'h1 : 3'h0;
  end
  // A busy bus takes one frame in eight cycles, so holding is exercised
  always_comb tx_ready = !slow || cnt == 3'h7;
endmodule
`default_nettype wire

// file: bench/tb_canopen_sdo_pdo_nmt_slave.sv
/*
  Self-checking bench of the CANopen slave: SDO service, NMT, SYNC PDOs.
  Assumes cn_slave, cn_ctl_model and cn_slave_sva compiled before.
*/
`include "cn_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module tb_canopen_sdo_pdo_nmt_slave;
  logic        sys_clk, rst_n, reg_wr, reg_rd, rx_valid, slow, rd_d;
  logic [3:0]  reg_addr, rx_dlc;
  logic [31:0] reg_wdata, seed;
  logic [10:0] rx_id;
  logic [63:0] rx_data, scanner_input_words;
  logic [15:0] status_word, motor_current, motor_thermal_state, fault_code;
  wire         rx_ready, tx_valid, tx_ready, command_strobe;
  wire  [31:0] reg_rdata;
  wire  [10:0] tx_id;
  wire  [3:0]  tx_dlc;
  wire  [63:0] tx_data, rpdo2_words, scanner_output_words;
  wire  [15:0] command_word;
  wire  [6:0]  nmt_state;
  logic [78:0] qf[$];
  logic [31:0] qr[$];
  int          n_errors, total_checks, cyc, i;
  localparam logic [6:0] ND = 7'h05;
  localparam logic [103:0] ROWS [13] = '{
    {8'h40, 16'h1234, 8'h00, 32'h0, 8'h80, `CN_AB_NOINDEX},
    {8'h40, 16'h6041, 8'h01, 32'h0, 8'h80, `CN_AB_NOSUB},
    {8'h2B, 16'h6041, 8'h00, 32'h1, 8'h80, `CN_AB_RDONLY},
    {8'hE0, 16'h6040, 8'h00, 32'h0, 8'h80, `CN_AB_CMD},
    {8'h60, 16'h6040, 8'h00, 32'h0, 8'h80, `CN_AB_TOGGLE},
    {8'h23, 16'h6040, 8'h00, 32'h1, 8'h80, `CN_AB_GENERAL},
    {8'h2F, 16'h1800, 8'h02, 32'hF1, 8'h80, `CN_AB_LIMIT},
    {8'h2B, 16'h1800, 8'h05, 32'hEA61, 8'h80, `CN_AB_HIGH},
    {8'h2F, 16'h1A01, 8'h00, 32'h5, 8'h80, `CN_AB_MAPLEN},
    {8'h23, 16'h1A01, 8'h01, 32'h12345610, 8'h80, `CN_AB_NOMAP},
    {8'h23, 16'h1801, 8'h01, 32'h0, 8'h60, 32'h0},
    {8'h2F, 16'h1A01, 8'h00, 32'h1, 8'h80, `CN_AB_ACCESS},
    {8'h23, 16'h1801, 8'h01, 32'h80000000, 8'h60, 32'h0}};
  cn_slave #(.TICK_CYC(4)) dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .rx_valid, .rx_ready, .rx_id, .rx_dlc,
    .rx_data, .tx_valid, .tx_ready, .tx_id, .tx_dlc, .tx_data, .status_word,
    .motor_current, .motor_thermal_state, .fault_code, .scanner_input_words,
    .command_word, .command_strobe, .rpdo2_words, .scanner_output_words,
    .nmt_state);
  cn_ctl_model far (.sys_clk, .rst_n, .slow, .tx_ready);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [78:0] got, input logic [78:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [10:0] id, input logic [3:0] dl,
                     input logic [63:0] d);
    int k;
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_dlc <= dl;
    rx_data <= d;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (rx_ready !== 1'b1 && k < 99);
    rx_valid <= 1'b0;
  endtask
  task automatic drain(input int n);
    for (int k = 0; k < n && qf.size() + qr.size() > 0; k++) @(posedge sys_clk);
    cmp(79'(qf.size() + qr.size()), 79'h0);
    qf.delete();
    qr.delete();
  endtask
  task automatic rg(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w) qr.push_back(d);
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  task automatic sdo(input logic [7:0] c, input logic [15:0] ix,
    input logic [7:0] sb, input logic [31:0] v, input logic [7:0] ec,
    input logic [31:0] ev);
    qf.push_back({`CN_COB_TSDO + ND, `CN_SDO_DLC, ev, sb, ix, ec});
    put(`CN_COB_RSDO + ND, `CN_SDO_DLC, {v, sb, ix, c});
    drain(300);
  endtask
  task automatic nmt(input logic [7:0] cs, input logic [7:0] node);
    put(`CN_COB_NMT, 4'h2, {48'h0, node, cs});
  endtask
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      cmp({tx_id, tx_dlc, tx_data}, qf.size() ? qf.pop_front() : 79'h0);
    if (rd_d === 1'b1)
      cmp(79'(reg_rdata), 79'(qr.size() ? qr.pop_front() : 32'hFFFFFFFF));
    cyc++;
    if (cyc > 30000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_n, reg_wr, reg_rd, rx_valid, slow} = 5'h0;
    {reg_addr, rx_dlc, reg_wdata, rx_id, rx_data} = 115'h0;
    {n_errors, total_checks, cyc} = 0;
    seed = xs(32'h7B7FAC21);
    {status_word, motor_current} = seed;
    seed = xs(seed);
    {motor_thermal_state, fault_code} = seed;
    scanner_input_words = {seed, xs(seed)};
    repeat (6) @(posedge sys_clk);
    qf.push_back({`CN_COB_BOOT + 11'h1, 4'h1, 64'h0});
    rst_n <= 1'b1;
    rg(1'b0, `CN_REG_NODE, 32'h1);
    rg(1'b0, `CN_REG_STAT, 32'h67F);
    rg(1'b0, 4'h8, 32'h0);
    rg(1'b1, `CN_REG_NODE, 32'h5);
    rg(1'b0, `CN_REG_NODE, 32'h5);
    drain(100);
    sdo(`CN_RQ_RD, 16'h2002, 8'h05, 32'h0, `CN_RS_RD2, motor_current);
    slow <= 1'b1;
    sdo(`CN_RQ_RD, 16'h6041, 8'h00, 32'h0, `CN_RS_RD2, status_word);
    sdo(`CN_RQ_WR2, 16'h6040, 8'h00, seed[31:16], `CN_RS_WR, 32'h0);
    sdo(`CN_RQ_RD, 16'h6040, 8'h00, 32'h0, `CN_RS_RD2, seed[31:16]);
    for (i = 0; i < 13; i++)
      sdo(ROWS[i][103:96], ROWS[i][95:80], ROWS[i][79:72], ROWS[i][71:40],
          ROWS[i][39:32], ROWS[i][31:0]);
    put(`CN_COB_RSDO + ND, `CN_SDO_DLC, {56'h0, `CN_RQ_CANCEL});
    put(`CN_COB_RSDO + ND, 4'h7, {56'h0, `CN_RQ_RD});
    sdo(`CN_RQ_WR1, 16'h1800, 8'h02, 32'h2, `CN_RS_WR, 32'h0);
    sdo(`CN_RQ_WR4, 16'h1402, 8'h01, 32'h0, `CN_RS_WR, 32'h0);
    nmt(`CN_CS_START, 8'h05);
    rg(1'b0, `CN_REG_STAT, 32'h605);
    put(`CN_COB_SYNC, 4'h0, 64'h0);
    drain(40);
    qf.push_back({`CN_COB_TPDO + ND, 4'h8, fault_code, motor_thermal_state,
                  motor_current, status_word});
    put(`CN_COB_SYNC, 4'h0, 64'h0);
    drain(300);
    put(`CN_COB_RPDO + 11'h100 + ND, 4'h8, scanner_input_words);
    put(`CN_COB_RPDO + 11'h200 + ND, 4'h8, scanner_input_words);
    put(`CN_COB_RPDO + ND, 4'h2, {48'h0, seed[15:0]});
    @(posedge sys_clk);
    cmp(79'({command_strobe, command_word}), 79'({1'b1, seed[15:0]}));
    cmp(79'(scanner_output_words), 79'(scanner_input_words));
    cmp(79'(rpdo2_words), 79'h0);
    sdo(`CN_RQ_RD, 16'h6040, 8'h00, 32'h0, `CN_RS_RD2, seed[15:0]);
    nmt(`CN_CS_PREOP, 8'h05);
    rg(1'b0, `CN_REG_STAT, 32'h67F);
    nmt(`CN_CS_STOP, 8'h00);
    put(`CN_COB_RSDO + ND, `CN_SDO_DLC, {56'h0, `CN_RQ_RD});
    rg(1'b0, `CN_REG_STAT, 32'h604);
    drain(60);
    for (i = 0; i < 2; i++) begin
      qf.push_back({`CN_COB_BOOT + ND, 4'h1, 64'h0});
      nmt(i ? `CN_CS_RST_COMM : `CN_CS_RST_NODE, 8'(i * 5));
      drain(300);
      rg(1'b0, `CN_REG_STAT, 32'h67F);
    end
    drain(20);
    conclude();
  end
endmodule
bind cn_slave cn_slave_sva chk (.sys_clk, .rst_n, .reg_rd, .reg_rdata,
  .tx_valid, .tx_ready, .tx_id, .tx_dlc, .tx_data, .nmt_state);
`default_nettype wire
